// ===== rtl/alkb_defs.vh
// shared constants of the acl lookup key builder
`ifndef ALKB_DEFS_VH
`define ALKB_DEFS_VH

// register byte offsets
`define ALKB_REG_CTRL 4'h0
`define ALKB_REG_GRP_IDX 4'h4
`define ALKB_REG_GRP_VAL 4'h8
`define ALKB_REG_STATUS 4'hc

// control register fields
`define ALKB_CTRL_IMP_BIT 0
`define ALKB_CTRL_HOST_BIT 1
`define ALKB_CTRL_VD_BIT 2
`define ALKB_CTRL_LOOP3_BIT 3
`define ALKB_CTRL_RST 4'h0

// per-port default policy group
`define ALKB_GROUP_RST 8'h00
`define ALKB_NUM_PORTS 53

// axi response codes
`define ALKB_RESP_OKAY 2'b00
`define ALKB_RESP_SLVERR 2'b10

// key geometry
`define ALKB_WORD_BITS 36
`define ALKB_KEY_BITS 576
`define ALKB_X4_BITS 88
`define ALKB_X8_BITS 284
`define ALKB_X16_BITS 567
`define ALKB_WORDS_X4 5'h04
`define ALKB_WORDS_X8 5'h08
`define ALKB_WORDS_X16 5'h10

// key size classes
`define ALKB_CLASS_X4 2'h0
`define ALKB_CLASS_X8 2'h1
`define ALKB_CLASS_X16 2'h2

// half key type codes
`define ALKB_HT_MAC_ETHERTYPE_KEY 4'h0
`define ALKB_HT_ARP 4'h3
`define ALKB_HT_IPV4_L4 4'h4
`define ALKB_HT_IPV4_MISC 4'h5
`define ALKB_HT_CUSTOM_B 4'h8
`define ALKB_HT_IPV6_VLAN 4'h9

// full key type codes
`define ALKB_FT_SEVEN_TUPLE 2'h1
`define ALKB_FT_CUSTOM_A 2'h2

// ingress mask modes
`define ALKB_MODE_PHYS 2'h0
`define ALKB_MODE_LOOP 2'h1
`define ALKB_MODE_IMP 2'h2
`define ALKB_MODE_SPECIAL 2'h3

// special port numbers
`define ALKB_PORT_HOST0 6'h35
`define ALKB_PORT_HOST1 6'h36
`define ALKB_PORT_VD0 6'h37
`define ALKB_PORT_VD1 6'h38
`define ALKB_PORT_LOOP 6'h39

// pipeline action meaning inject_impersonate
`define ALKB_ACT_INJ_IMP 3'h4

// dmac group bit
`define ALKB_DMAC_GROUP_BIT 40

`endif

// ===== rtl/alkb_mask.v
// ingress mask mode and ingress port bitmap selection
`timescale 1ns/100ps
`default_nettype none
`include "alkb_defs.vh"

module alkb_mask (
   input wire [5:0] phys_port_in, // physical source port
   input wire [5:0] loop_port_in, // port on which the frame looped
   input wire [5:0] ifh_src_port_in, // injection header source port
   input wire ifh_inject_in, // ifh_dest_mode is inject
   input wire [4:0] pipe_point_in, // pipeline_point
   input wire [2:0] pipe_action_in, // pipeline_action
   input wire imp_en_in, // impersonation_mask_enable
   input wire host_en_in, // host_inject_mask_enable
   input wire vd_en_in, // virtual_dev_mask_enable
   input wire loop3_en_in, // loop_mode3_enable
   output reg [1:0] mode_out, // ingress_mask_mode
   output reg [52:0] bitmap_out // ingress_port_bitmap
);

   wire is_host0;
   wire is_host1;
   wire is_vd0;
   wire is_vd1;
   wire is_loop;
   wire is_masq;
   wire want3;
   wire [5:0] eff_port;

   function [52:0] onehot;
      input [5:0] p;
      begin
         onehot = 53'h0;
         if (p < `ALKB_NUM_PORTS) begin
            onehot[p] = 1'b1;
         end
      end
   endfunction

   assign is_host0 = (phys_port_in == `ALKB_PORT_HOST0);
   assign is_host1 = (phys_port_in == `ALKB_PORT_HOST1);
   assign is_vd0 = (phys_port_in == `ALKB_PORT_VD0);
   assign is_vd1 = (phys_port_in == `ALKB_PORT_VD1);
   assign is_loop = (phys_port_in == `ALKB_PORT_LOOP);
   assign is_masq = (ifh_inject_in && (ifh_src_port_in != phys_port_in)) ||
      (pipe_action_in == `ALKB_ACT_INJ_IMP);
   assign want3 = ((is_host0 || is_host1) && host_en_in) ||
      ((is_vd0 || is_vd1) && vd_en_in) || (is_loop && loop3_en_in);
   // source port seen after masquerade or loop
   assign eff_port = is_loop ? loop_port_in : (is_masq ? ifh_src_port_in : phys_port_in);

   always @* begin
      // highest applicable mode wins
      if (want3) begin
         mode_out = `ALKB_MODE_SPECIAL;
      end else if (is_masq && imp_en_in) begin
         mode_out = `ALKB_MODE_IMP;
      end else if (is_loop) begin
         mode_out = `ALKB_MODE_LOOP;
      end else begin
         mode_out = `ALKB_MODE_PHYS;
      end
   end

   always @* begin
      case (mode_out)
         `ALKB_MODE_PHYS: begin
            bitmap_out = onehot(phys_port_in);
         end
         `ALKB_MODE_LOOP: begin
            bitmap_out = onehot(loop_port_in);
         end
         `ALKB_MODE_IMP: begin
            bitmap_out = onehot(ifh_src_port_in);
         end
         default: begin
            // gap between source port and pipeline point stays zero
            bitmap_out = {1'b0, pipe_action_in, pipe_point_in, 34'h0, eff_port,
               is_vd1, is_vd0, is_host1, is_host0};
         end
      endcase
   end

endmodule
`default_nettype wire

// ===== rtl/alkb_top.v
// acl lookup key builder with axi4-lite configuration slave
//
// How it works
// - four-word ipv4 vlan key, 88 bits; code packs only first flag and group, bits 8:0
// - eight- and sixteen-word key sizes per type
// - fields packed contiguously from bit zero
// - half-key type code in bits 3:0
// - two-bit full-key type at key start
// - first-pass flag set first, cleared second
// - policy group from port default or override
// - mask mode 0 default, 1 loop device
// - mode 2 for masquerade when enabled
// - masquerade by inject port mismatch or action
// - mode 3 for host, virtual, loop cases
// - highest applicable mask mode wins
// - one-hot bitmap per mode 0..2
// - mode 3 bitmap special field layout
// - multicast flag from dmac bit 40
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "alkb_defs.vh"

module alkb_top (
   input wire MCLK_IN, // core clock, 50 MHz
   input wire NRST_IN, // async reset, active low
   // axi4-lite slave
   input wire [3:0] AWADDR_IN, // write address
   input wire AWVALID_IN, // write address valid
   output wire AWREADY_OUT, // write address ready
   input wire [31:0] WDATA_IN, // write data
   input wire [3:0] WSTRB_IN, // write strobes
   input wire WVALID_IN, // write data valid
   output wire WREADY_OUT, // write data ready
   output wire [1:0] BRESP_OUT, // write response
   output wire BVALID_OUT, // write response valid
   input wire BREADY_IN, // write response ready
   input wire [3:0] ARADDR_IN, // read address
   input wire ARVALID_IN, // read address valid
   output wire ARREADY_OUT, // read address ready
   output wire [31:0] RDATA_OUT, // read data
   output wire [1:0] RRESP_OUT, // read response
   output wire RVALID_OUT, // read data valid
   input wire RREADY_IN, // read data ready
   // lookup request from classification
   input wire LKP_VALID_IN, // request pulse
   input wire LKP_FIRST_IN, // high for first lookup
   input wire [1:0] LKP_CLASS_IN, // key size class
   input wire [3:0] LKP_TYPE_IN, // half or full key type code
   input wire [5:0] LKP_PHYS_PORT_IN, // physical source port
   input wire [5:0] LKP_LOOP_PORT_IN, // port the frame looped on
   input wire [5:0] LKP_IFH_SRC_PORT_IN, // injection header source port
   input wire LKP_IFH_INJECT_IN, // ifh_dest_mode is inject
   input wire [4:0] LKP_PIPE_POINT_IN, // pipeline_point
   input wire [2:0] LKP_PIPE_ACTION_IN, // pipeline_action
   input wire LKP_GROUP_OVR_IN, // earlier lookup changed the group
   input wire [7:0] LKP_GROUP_IN, // policy group from earlier lookup
   input wire [47:0] LKP_DMAC_IN, // destination mac
   // key to match array
   output wire KEY_VALID_OUT, // key pulse
   output wire KEY_ERR_OUT, // bad class or type, key is zero
   output wire [4:0] KEY_WORDS_OUT, // words in key
   output wire [575:0] KEY_DATA_OUT // packed key
);

   reg awready_q;
   reg wready_q;
   reg aw_held_q;
   reg w_held_q;
   reg [3:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg arready_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;
   reg started_q;
   reg [3:0] ctrl_q;
   reg [5:0] grp_idx_q;
   reg [15:0] key_cnt_q;
   reg [1:0] last_mode_q;
   reg last_err_q;
   reg key_valid_q;
   reg key_err_q;
   reg [4:0] key_words_q;
   reg [575:0] key_q;
   reg [575:0] key_d;
   reg [4:0] words_d;
   reg err_d;
   reg [31:0] rd_mux;
   reg rd_ok;
   wire do_write;
   wire grp_we;
   wire [7:0] grp_rd;
   wire [7:0] port_group;
   wire [7:0] pol_group;
   wire [1:0] mode;
   wire [52:0] bitmap;
   wire mc_flag;
   wire [64:0] common;
   wire [7:0] grp_q [0:52];

   assign AWREADY_OUT = awready_q;
   assign WREADY_OUT = wready_q;
   assign BVALID_OUT = bvalid_q;
   assign BRESP_OUT = bresp_q;
   assign ARREADY_OUT = arready_q;
   assign RVALID_OUT = rvalid_q;
   assign RDATA_OUT = rdata_q;
   assign RRESP_OUT = rresp_q;
   assign KEY_VALID_OUT = key_valid_q;
   assign KEY_ERR_OUT = key_err_q;
   assign KEY_WORDS_OUT = key_words_q;
   assign KEY_DATA_OUT = key_q;

   assign do_write = aw_held_q && w_held_q && !bvalid_q;
   assign grp_we = do_write && (awaddr_q == `ALKB_REG_GRP_VAL) && wstrb_q[0];

   // per-port default policy group table
   genvar gi;
   generate
      for (gi = 0; gi < `ALKB_NUM_PORTS; gi = gi + 1) begin : g_grp
         reg [7:0] ent_q;
         always @(posedge MCLK_IN or negedge NRST_IN) begin
            if (!NRST_IN) begin
               ent_q <= `ALKB_GROUP_RST;
            end else if (grp_we && (grp_idx_q == gi)) begin
               ent_q <= wdata_q[7:0];
            end
         end
         assign grp_q[gi] = ent_q;
      end
   endgenerate

   assign grp_rd = (grp_idx_q < `ALKB_NUM_PORTS) ? grp_q[grp_idx_q] : 8'h00;
   assign port_group = (LKP_PHYS_PORT_IN < `ALKB_NUM_PORTS) ?
      grp_q[LKP_PHYS_PORT_IN] : `ALKB_GROUP_RST;
   assign pol_group = LKP_GROUP_OVR_IN ? LKP_GROUP_IN : port_group;

   // axi write channel
   always @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         started_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `ALKB_RESP_OKAY;
         ctrl_q <= `ALKB_CTRL_RST;
         grp_idx_q <= 6'h00;
      end else begin
         started_q <= 1'b1;
         if (!started_q) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
         if (AWVALID_IN && awready_q) begin
            awready_q <= 1'b0;
            aw_held_q <= 1'b1;
            awaddr_q <= {AWADDR_IN[3:2], 2'b00};
         end
         if (WVALID_IN && wready_q) begin
            wready_q <= 1'b0;
            w_held_q <= 1'b1;
            wdata_q <= WDATA_IN;
            wstrb_q <= WSTRB_IN;
         end
         if (do_write) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= `ALKB_RESP_OKAY;
            case (awaddr_q)
               `ALKB_REG_CTRL: begin
                  if (wstrb_q[0]) begin
                     ctrl_q <= wdata_q[3:0];
                  end
               end
               `ALKB_REG_GRP_IDX: begin
                  if (wstrb_q[0]) begin
                     grp_idx_q <= wdata_q[5:0];
                  end
               end
               `ALKB_REG_GRP_VAL: begin
                  bresp_q <= `ALKB_RESP_OKAY;
               end
               default: begin
                  bresp_q <= `ALKB_RESP_SLVERR;
               end
            endcase
         end
         if (bvalid_q && BREADY_IN) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // read mux
   always @* begin
      rd_ok = 1'b1;
      case ({ARADDR_IN[3:2], 2'b00})
         `ALKB_REG_CTRL: begin
            rd_mux = {28'h0, ctrl_q};
         end
         `ALKB_REG_GRP_IDX: begin
            rd_mux = {26'h0, grp_idx_q};
         end
         `ALKB_REG_GRP_VAL: begin
            rd_mux = {24'h0, grp_rd};
         end
         `ALKB_REG_STATUS: begin
            rd_mux = {13'h0, last_err_q, last_mode_q, key_cnt_q};
         end
         default: begin
            rd_mux = 32'h0;
            rd_ok = 1'b0;
         end
      endcase
   end

   // axi read channel
   always @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= `ALKB_RESP_OKAY;
      end else begin
         if (!started_q) begin
            arready_q <= 1'b1;
         end
         if (ARVALID_IN && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_ok ? `ALKB_RESP_OKAY : `ALKB_RESP_SLVERR;
         end
         if (rvalid_q && RREADY_IN) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end

   alkb_mask u_mask (
      .phys_port_in(LKP_PHYS_PORT_IN),
      .loop_port_in(LKP_LOOP_PORT_IN),
      .ifh_src_port_in(LKP_IFH_SRC_PORT_IN),
      .ifh_inject_in(LKP_IFH_INJECT_IN),
      .pipe_point_in(LKP_PIPE_POINT_IN),
      .pipe_action_in(LKP_PIPE_ACTION_IN),
      .imp_en_in(ctrl_q[`ALKB_CTRL_IMP_BIT]),
      .host_en_in(ctrl_q[`ALKB_CTRL_HOST_BIT]),
      .vd_en_in(ctrl_q[`ALKB_CTRL_VD_BIT]),
      .loop3_en_in(ctrl_q[`ALKB_CTRL_LOOP3_BIT]),
      .mode_out(mode),
      .bitmap_out(bitmap)
   );

   assign mc_flag = LKP_DMAC_IN[`ALKB_DMAC_GROUP_BIT];
   // first, group, mode, bitmap, multicast, from low to high
   assign common = {mc_flag, bitmap, mode, pol_group, LKP_FIRST_IN};

   // key packing
   always @* begin
      key_d = 576'h0;
      words_d = 5'h00;
      err_d = 1'b0;
      case (LKP_CLASS_IN)
         `ALKB_CLASS_X4: begin
            words_d = `ALKB_WORDS_X4;
            key_d[8:0] = {pol_group, LKP_FIRST_IN};
         end
         `ALKB_CLASS_X8: begin
            words_d = `ALKB_WORDS_X8;
            case (LKP_TYPE_IN)
               `ALKB_HT_MAC_ETHERTYPE_KEY, `ALKB_HT_ARP, `ALKB_HT_IPV4_L4,
               `ALKB_HT_IPV4_MISC, `ALKB_HT_CUSTOM_B, `ALKB_HT_IPV6_VLAN: begin
                  key_d[68:0] = {common, LKP_TYPE_IN};
               end
               default: begin
                  err_d = 1'b1;
               end
            endcase
         end
         `ALKB_CLASS_X16: begin
            words_d = `ALKB_WORDS_X16;
            if (LKP_TYPE_IN == {2'b00, `ALKB_FT_SEVEN_TUPLE} ||
               LKP_TYPE_IN == {2'b00, `ALKB_FT_CUSTOM_A}) begin
               key_d[66:0] = {common, LKP_TYPE_IN[1:0]};
            end else begin
               err_d = 1'b1;
            end
         end
         default: begin
            err_d = 1'b1;
         end
      endcase
   end

   // key register and status
   always @(posedge MCLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         key_valid_q <= 1'b0;
         key_err_q <= 1'b0;
         key_words_q <= 5'h00;
         key_q <= 576'h0;
         key_cnt_q <= 16'h0000;
         last_mode_q <= `ALKB_MODE_PHYS;
         last_err_q <= 1'b0;
      end else begin
         key_valid_q <= LKP_VALID_IN;
         key_err_q <= LKP_VALID_IN && err_d;
         if (LKP_VALID_IN) begin
            key_words_q <= words_d;
            key_q <= key_d;
            key_cnt_q <= key_cnt_q + 16'h0001;
            last_mode_q <= mode;
            last_err_q <= err_d;
         end
      end
   end

endmodule
`default_nettype wire

// ===== verification/alkb_checker.sv
// assertions on the key builder top ports
`timescale 1ns/100ps
`default_nettype none
module alkb_checker (
   input wire logic MCLK_IN, // clock
   input wire logic NRST_IN, // reset
   input wire logic LKP_VALID_IN, // request
   input wire logic LKP_FIRST_IN, // first lookup
   input wire logic [1:0] LKP_CLASS_IN, // size class
   input wire logic [3:0] LKP_TYPE_IN, // type code
   input wire logic [5:0] LKP_PHYS_PORT_IN, // phys port
   input wire logic LKP_IFH_INJECT_IN, // injected
   input wire logic [4:0] LKP_PIPE_POINT_IN, // pipeline point
   input wire logic [2:0] LKP_PIPE_ACTION_IN, // pipeline action
   input wire logic LKP_GROUP_OVR_IN, // group override
   input wire logic [7:0] LKP_GROUP_IN, // override group
   input wire logic [47:0] LKP_DMAC_IN, // dest mac
   input wire logic KEY_VALID_OUT, // key pulse
   input wire logic [4:0] KEY_WORDS_OUT, // words
   input wire logic [575:0] KEY_DATA_OUT // key
);
   wire x8 = LKP_VALID_IN && LKP_CLASS_IN == 2'h1
      && (LKP_TYPE_IN inside {4'h0, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9});
   default clocking @(posedge MCLK_IN);
   endclocking
   default disable iff (!NRST_IN);
   AST_X4_SIZE: assert property (
      LKP_VALID_IN && LKP_CLASS_IN == 2'h0 |=> KEY_VALID_OUT && KEY_WORDS_OUT == 5'h04
      && KEY_DATA_OUT[575:9] == '0) else $error("four word key wrong");
   AST_X8_SIZE: assert property (
      x8 |=> KEY_WORDS_OUT == 5'h08 && KEY_DATA_OUT[575:69] == '0)
      else $error("eight word key wrong");
   AST_FULL_KEY_TYPE: assert property (
      LKP_VALID_IN && LKP_CLASS_IN == 2'h2 && (LKP_TYPE_IN inside {4'h1, 4'h2})
      |=> KEY_WORDS_OUT == 5'h10 && {2'h0, KEY_DATA_OUT[1:0]} == $past(LKP_TYPE_IN))
      else $error("sixteen word key wrong");
   AST_HALF_TYPE: assert property (
      x8 |=> KEY_DATA_OUT[3:0] == $past(LKP_TYPE_IN)) else $error("half key type wrong");
   AST_FIRST_FLAG: assert property (
      x8 |=> KEY_DATA_OUT[4] == $past(LKP_FIRST_IN)) else $error("first flag wrong");
   AST_GROUP_OVR: assert property (
      x8 && LKP_GROUP_OVR_IN |=> KEY_DATA_OUT[12:5] == $past(LKP_GROUP_IN))
      else $error("policy group wrong");
   AST_MODE_ZERO: assert property (
      x8 && LKP_PHYS_PORT_IN < 6'h35 && !LKP_IFH_INJECT_IN && LKP_PIPE_ACTION_IN != 3'h4
      |=> KEY_DATA_OUT[14:13] == 2'h0
      && KEY_DATA_OUT[67:15] == 53'h1 << $past(LKP_PHYS_PORT_IN))
      else $error("default mask mode wrong");
   AST_ONEHOT: assert property (
      x8 |=> KEY_DATA_OUT[14:13] == 2'h3 || $onehot0(KEY_DATA_OUT[67:15]))
      else $error("bitmap not one hot");
   AST_MODE3_MAP: assert property (
      x8 |=> KEY_DATA_OUT[14:13] != 2'h3 || KEY_DATA_OUT[58:25] == '0 && !KEY_DATA_OUT[67]
      && KEY_DATA_OUT[63:59] == $past(LKP_PIPE_POINT_IN)
      && KEY_DATA_OUT[66:64] == $past(LKP_PIPE_ACTION_IN)) else $error("mode 3 map wrong");
   AST_MC_FLAG: assert property (
      x8 |=> KEY_DATA_OUT[68] == |($past(LKP_DMAC_IN) & 48'h010000000000))
      else $error("multicast flag wrong");
endmodule
`default_nettype wire

// ===== verification/alkb_match_model.sv
// match array stand-in counting delivered keys
`timescale 1ns/100ps
`default_nettype none
module alkb_match_model (
   input wire logic clk_in, // core clock
   input wire logic rst_n_in, // async reset
   input wire logic key_valid_in, // key pulse
   output logic [15:0] keys_out // keys taken
);
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
         keys_out <= 16'h0;
      else if (key_valid_in)
         keys_out <= keys_out + 16'h1;
   end
endmodule
`default_nettype wire

// ===== verification/alkb_top_tb_top.sv
// self-checking bench for the acl lookup key builder
`timescale 1ns/100ps
`default_nettype none
module alkb_top_tb_top;
   logic clk, rst_n, awv, wv, br, arv, rr, lv, lf, lo, li, gm, go;
   logic awr, wrd, bv, arr, rv, kv, ke;
   logic [3:0] awa, ara, lt;
   logic [31:0] wd, rd;
   logic [1:0] lc, bre, rre;
   logic [5:0] lp, ll, ls;
   logic [2:0] la;
   logic [47:0] ldm;
   logic [4:0] kw, lpp, pt;
   logic [7:0] lgi;
   logic [575:0] kd;
   logic [15:0] nk;
   int n_errors, compares, nl;
   logic [3:0] ht [6] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9};
   alkb_top alkb_top_i (
      .MCLK_IN(clk), .NRST_IN(rst_n), .AWADDR_IN(awa), .AWVALID_IN(awv), .AWREADY_OUT(awr),
      .WDATA_IN(wd), .WSTRB_IN(4'hf), .WVALID_IN(wv), .WREADY_OUT(wrd), .BRESP_OUT(bre),
      .BVALID_OUT(bv), .BREADY_IN(br), .ARADDR_IN(ara), .ARVALID_IN(arv), .ARREADY_OUT(arr),
      .RDATA_OUT(rd), .RRESP_OUT(rre), .RVALID_OUT(rv), .RREADY_IN(rr), .LKP_VALID_IN(lv),
      .LKP_FIRST_IN(lf), .LKP_CLASS_IN(lc), .LKP_TYPE_IN(lt), .LKP_PHYS_PORT_IN(lp),
      .LKP_LOOP_PORT_IN(ll), .LKP_IFH_SRC_PORT_IN(ls), .LKP_IFH_INJECT_IN(li),
      .LKP_PIPE_POINT_IN(lpp), .LKP_PIPE_ACTION_IN(la), .LKP_GROUP_OVR_IN(lo),
      .LKP_GROUP_IN(lgi), .LKP_DMAC_IN(ldm), .KEY_VALID_OUT(kv), .KEY_ERR_OUT(ke),
      .KEY_WORDS_OUT(kw), .KEY_DATA_OUT(kd));
   alkb_match_model alkb_match_model_i (.clk_in(clk), .rst_n_in(rst_n), .key_valid_in(kv),
      .keys_out(nk));
   function automatic [52:0] oh(input [5:0] p);
      oh = 53'h1 << p;
   endfunction
   function automatic [52:0] m3(input [3:0] b, input [5:0] p, input [2:0] a);
      m3 = {1'b0, a, pt, 34'h0, p, b};
   endfunction
   function automatic [575:0] kx(input [1:0] c, input [3:0] t, input f, input [7:0] g,
      input [1:0] m, input [52:0] b, input mc);
      begin
         kx = '0;
         if (c == 2'h0)
            kx[8:0] = {g, f};
         else if (c == 2'h1)
            kx[68:0] = {mc, b, m, g, f, t};
         else
            kx[66:0] = {mc, b, m, g, f, t[1:0]};
      end
   endfunction
   task automatic results;
      begin
         $display("mismatches %0d of %0d compares", n_errors, compares);
         if (n_errors == 0 && compares > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task automatic chk32(input logic [31:0] g, e);
      begin
         compares++;
         if (g !== e) begin
            n_errors++;
            $display("unexpected value at %0t: %h not %h", $time, g, e);
         end
      end
   endtask
   task automatic chk_key(input logic [575:0] e, input logic [4:0] w, input logic er);
      begin
         compares++;
         if (kv !== 1'b1 || ke !== er || kw !== w || kd !== e) begin
            n_errors++;
            $display("unexpected key at %0t: %h", $time, kd[68:0]);
         end
      end
   endtask
   task automatic axw(input [3:0] a, input [31:0] d);
      begin
         @(posedge clk);
         awv <= 1'b1;
         wv <= 1'b1;
         awa <= a;
         wd <= d;
         br <= 1'b1;
         do begin
            @(posedge clk);
            if (awr === 1'b1)
               awv <= 1'b0;
            if (wrd === 1'b1)
               wv <= 1'b0;
         end while (bv !== 1'b1);
         br <= 1'b0;
         chk32({30'h0, bre}, 32'h0);
      end
   endtask
   task automatic axr(input [3:0] a, input [31:0] e);
      begin
         @(posedge clk);
         arv <= 1'b1;
         ara <= a;
         rr <= 1'b1;
         do begin
            @(posedge clk);
            if (arr === 1'b1)
               arv <= 1'b0;
         end while (rv !== 1'b1);
         rr <= 1'b0;
         chk32(rd, e);
         chk32({30'h0, rre}, 32'h0);
      end
   endtask
   task automatic tk(input [1:0] c, input [3:0] t, input f, input [5:0] p, l, s, input i,
      input [2:0] a, input [7:0] g, input [1:0] m, input [52:0] b);
      logic er;
      begin
         // bad class or type gives an all-zero key with the error pulse
         er = (c == 2'h3) || (c == 2'h1 && !(t inside {4'h0, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9}))
            || (c == 2'h2 && !(t inside {4'h1, 4'h2}));
         @(posedge clk);
         lv <= 1'b1;
         lc <= c;
         lt <= t;
         lf <= f;
         lp <= p;
         ll <= l;
         ls <= s;
         li <= i;
         la <= a;
         lo <= go;
         // override group differs from the expected one unless it is taken
         lgi <= go ? g : ~g;
         lpp <= pt;
         ldm <= {7'h0, gm, 40'h0};
         @(posedge clk);
         lv <= 1'b0;
         nl++;
         #1;
         chk_key(er ? '0 : kx(c, t, f, g, m, b, gm), c == 2'h0 ? 5'h04 : c == 2'h1 ? 5'h08 :
            c == 2'h2 ? 5'h10 : 5'h00, er);
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #100000;
      n_errors++;
      results;
   end
   initial begin
      {awv, wv, br, arv, rr, lv, lf, lo, li, gm, go, awa, ara, lt, wd, lc, lp, ll, ls, la} = '0;
      ldm = 48'h0;
      {lpp, lgi} = '0;
      pt = 5'h15;
      rst_n = 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      axr(4'h0, 32'h0);
      axw(4'h4, 32'h5);
      axw(4'h8, 32'ha5);
      axr(4'h8, 32'ha5);
      tk(2'h0, 4'h0, 1'b1, 6'h05, 6'h00, 6'h00, 1'b0, 3'h0, 8'ha5, 2'h0, 53'h0);
      foreach (ht[i]) begin
         gm = i[0];
         tk(2'h1, ht[i], i[0], 6'h05, 6'h00, 6'h00, 1'b0, 3'h0, 8'ha5, 2'h0, oh(6'h05));
      end
      for (int j = 1; j < 3; j++) begin
         tk(2'h2, 4'(j), 1'b0, 6'h05, 6'h00, 6'h00, 1'b0, 3'h0, 8'ha5, 2'h0, oh(6'h05));
      end
      go = 1'b1;
      tk(2'h1, 4'h3, 1'b0, 6'h05, 6'h00, 6'h00, 1'b0, 3'h0, 8'h3c, 2'h0, oh(6'h05));
      go = 1'b0;
      tk(2'h3, 4'h0, 1'b1, 6'h05, 6'h00, 6'h00, 1'b0, 3'h0, 8'ha5, 2'h0, oh(6'h05));
      tk(2'h2, 4'h3, 1'b1, 6'h05, 6'h00, 6'h00, 1'b0, 3'h0, 8'ha5, 2'h0, oh(6'h05));
      tk(2'h1, 4'h1, 1'b1, 6'h05, 6'h00, 6'h00, 1'b0, 3'h0, 8'ha5, 2'h0, oh(6'h05));
      axr(4'hc, {13'h0, 1'b1, 2'h0, 16'(nl)});
      tk(2'h1, 4'h4, 1'b1, 6'h39, 6'h0c, 6'h00, 1'b0, 3'h0, 8'h00, 2'h1, oh(6'h0c));
      tk(2'h1, 4'h5, 1'b1, 6'h05, 6'h00, 6'h09, 1'b1, 3'h0, 8'ha5, 2'h0, oh(6'h05));
      axw(4'h0, 32'h1);
      tk(2'h1, 4'h8, 1'b1, 6'h05, 6'h00, 6'h09, 1'b1, 3'h0, 8'ha5, 2'h2, oh(6'h09));
      tk(2'h1, 4'h9, 1'b1, 6'h05, 6'h00, 6'h09, 1'b0, 3'h4, 8'ha5, 2'h2, oh(6'h09));
      tk(2'h1, 4'h0, 1'b1, 6'h05, 6'h00, 6'h05, 1'b1, 3'h0, 8'ha5, 2'h0, oh(6'h05));
      tk(2'h1, 4'h0, 1'b0, 6'h39, 6'h0c, 6'h09, 1'b1, 3'h0, 8'h00, 2'h2, oh(6'h09));
      axw(4'h0, 32'hf);
      axr(4'h0, 32'hf);
      tk(2'h1, 4'h0, 1'b1, 6'h39, 6'h0c, 6'h09, 1'b1, 3'h0, 8'h00, 2'h3,
         m3(4'h0, 6'h0c, 3'h0));
      pt = 5'h0a;
      tk(2'h1, 4'h3, 1'b1, 6'h35, 6'h00, 6'h00, 1'b0, 3'h3, 8'h00, 2'h3,
         m3(4'h1, 6'h35, 3'h3));
      tk(2'h1, 4'h4, 1'b0, 6'h38, 6'h00, 6'h00, 1'b0, 3'h0, 8'h00, 2'h3,
         m3(4'h8, 6'h38, 3'h0));
      axr(4'hc, {13'h0, 1'b0, 2'h3, 16'(nl)});
      repeat (2) @(posedge clk);
      chk32({16'h0, nk}, 32'(nl));
      results;
   end
endmodule
bind alkb_top alkb_checker alkb_checker_i (.MCLK_IN, .NRST_IN, .LKP_VALID_IN, .LKP_FIRST_IN,
   .LKP_CLASS_IN, .LKP_TYPE_IN, .LKP_PHYS_PORT_IN, .LKP_IFH_INJECT_IN, .LKP_PIPE_POINT_IN,
   .LKP_PIPE_ACTION_IN, .LKP_GROUP_OVR_IN, .LKP_GROUP_IN, .LKP_DMAC_IN, .KEY_VALID_OUT,
   .KEY_WORDS_OUT, .KEY_DATA_OUT);
`default_nettype wire
